// [pkg/hcr_pkg.sv]
// HDLC controller configuration bank: shared constants and types.
// Assumes one 50 MHz clock and a 32-bit classic Wishbone slave port.
package hcr_pkg;

  ////////////////////////////////////////////////////////////////////
  // Clocking and settle time
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SETTLE_NS = 625_000;
  // Least time, so round up
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////
  // Capacity figures
  localparam int unsigned NUM_PORTS = 16;
  localparam int unsigned NUM_CHANNELS = 256;
  localparam int unsigned NUM_TIMESLOTS = 128;
  localparam int unsigned CP_REGS_PER_TS = 3;
  localparam int unsigned NUM_FIFO_BLOCKS = 1024;
  localparam int unsigned NUM_FAST_PORTS = 3;
  localparam int unsigned FAST_RATE_MBPS = 52;
  localparam int unsigned SLOW_RATE_MBPS = 10;
  localparam int unsigned MAX_THRU_MBPS = 132;
  localparam int unsigned MAX_LINES = 64;

  ////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_RESET_ID = 12'h000;
  localparam logic [11:0] OFS_MASTER_CFG = 12'h004;
  localparam logic [11:0] OFS_BRIDGE_MODE = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_CP_ADDR = 12'h040;
  localparam logic [11:0] OFS_CP_DATA = 12'h044;
  localparam logic [11:0] OFS_FB_ADDR = 12'h048;
  localparam logic [11:0] OFS_RX_FB_DATA = 12'h04C;
  localparam logic [11:0] OFS_TX_FB_DATA = 12'h050;
  localparam logic [11:0] OFS_CH_ADDR = 12'h054;
  localparam logic [11:0] OFS_RX_START = 12'h058;
  localparam logic [11:0] OFS_RX_HWM = 12'h05C;
  localparam logic [11:0] OFS_TX_START = 12'h060;
  localparam logic [11:0] OFS_TX_LWM = 12'h064;
  localparam logic [11:0] OFS_PORT_CFG = 12'h100;

  ////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int unsigned RST_BIT = 0;
  localparam int unsigned ID_LSB = 4;
  localparam int unsigned RX_DMA_BIT = 0;
  localparam int unsigned TX_DMA_BIT = 1;
  localparam int unsigned ST_READY_BIT = 0;
  localparam int unsigned ST_RATE_BIT = 1;
  localparam int unsigned ST_THRU_BIT = 2;
  localparam int unsigned ST_LINE_BIT = 3;
  localparam int unsigned ST_FAST_BIT = 4;
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;
  // Identity code: value is arbitrary
  localparam logic [11:0] ID_DEFAULT = 12'h5A3;

  // Per-port configuration word
  typedef struct packed {
    logic [4:0] unused;
    logic fast;
    logic [1:0] lines;
    logic [5:0] rate;
    logic chan;
    logic en;
  } hcr_port_cfg_t;

  // Indirect channelized port address word
  typedef struct packed {
    logic [2:0] unused;
    logic [3:0] port;
    logic [6:0] slot;
    logic [1:0] sel;
  } hcr_cp_addr_t;

endpackage

// [src/hcr_settle_timer.sv]
// Port settle timer: ready rises a fixed count after restart.
// Assumes restart is a synchronous one-cycle pulse.
`timescale 1ns/100ps
module hcr_settle_timer #(
  parameter int unsigned CYCLES = hcr_pkg::SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic restart,
  output logic ready
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  ////////////////////////////////////////////////////////////////////
  // Count up, hold ready once the interval passes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      ready <= 1'b0;
    end else if (restart) begin
      count <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      count <= count + CW'(1);
      ready <= (count == LAST);
    end
  end

endmodule

// [src/hcr_config_bank.sv]
// HDLC controller configuration bank with indirect stores.
// Assumes a classic Wishbone master on ref_clk; reset is the
// hardware reset pin, asynchronous and active high.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
module hcr_config_bank #(
  parameter int unsigned SETTLE_CYCLES = hcr_pkg::SETTLE_CYC,
  parameter logic [11:0] DEVICE_ID = hcr_pkg::ID_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rx_dma_global_enable,
  output logic tx_dma_global_enable,
  output logic [15:0] bridge_mode,
  output logic ports_ready,
  output logic [15:0] port_run,
  output logic [15:0] port_channelized
);

  localparam int unsigned NP = hcr_pkg::NUM_PORTS;
  localparam int unsigned NCH = hcr_pkg::NUM_CHANNELS;
  localparam int unsigned NFB = hcr_pkg::NUM_FIFO_BLOCKS;
  localparam int unsigned NCP =
    NP * hcr_pkg::NUM_TIMESLOTS * hcr_pkg::CP_REGS_PER_TS;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  logic req;
  logic wr;
  logic lane;
  logic [11:0] ofs;
  logic sw_reset;

  // New request seen; answered next edge
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Any lane enables a full 16-bit access
  assign lane = |wb_sel_i;
  assign wr = req && wb_we_i && lane;
  assign ofs = {wb_adr_i[11:2], 2'b00};

  ////////////////////////////////////////////////////////////////////
  // Direct registers
  logic [15:0] master_config_reg;
  logic [15:0] bridge_mode_control_reg;
  hcr_pkg::hcr_port_cfg_t port_cfg [NP];
  hcr_pkg::hcr_cp_addr_t cp_addr;
  logic [15:0] fb_addr;
  logic [15:0] ch_addr;
  logic [15:0] status;

  // Software reset pulse from the reset word
  assign sw_reset = wr && ofs == hcr_pkg::OFS_RESET_ID
    && wb_dat_i[hcr_pkg::RST_BIT];

  // Master configuration: DMA global enables
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      master_config_reg <= hcr_pkg::REG_RESET_VAL;
    end else if (sw_reset) begin
      master_config_reg <= hcr_pkg::REG_RESET_VAL;
    end else if (wr && ofs == hcr_pkg::OFS_MASTER_CFG) begin
      master_config_reg <= wb_dat_i[15:0];
    end
  end

  // Bridge mode: hardware reset only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bridge_mode_control_reg <= hcr_pkg::REG_RESET_VAL;
    end else if (wr && ofs == hcr_pkg::OFS_BRIDGE_MODE) begin
      bridge_mode_control_reg <= wb_dat_i[15:0];
    end
  end

  // Indirect address words
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cp_addr <= hcr_pkg::REG_RESET_VAL;
      fb_addr <= hcr_pkg::REG_RESET_VAL;
      ch_addr <= hcr_pkg::REG_RESET_VAL;
    end else if (sw_reset) begin
      cp_addr <= hcr_pkg::REG_RESET_VAL;
      fb_addr <= hcr_pkg::REG_RESET_VAL;
      ch_addr <= hcr_pkg::REG_RESET_VAL;
    end else if (wr) begin
      if (ofs == hcr_pkg::OFS_CP_ADDR) begin
        cp_addr <= wb_dat_i[15:0];
      end
      if (ofs == hcr_pkg::OFS_FB_ADDR) begin
        fb_addr <= wb_dat_i[15:0];
      end
      if (ofs == hcr_pkg::OFS_CH_ADDR) begin
        ch_addr <= wb_dat_i[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-port configuration words
  genvar gp;
  logic [NP-1:0] rate_err;
  logic [NP-1:0] fast_err;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      localparam logic [11:0] PORT_OFS =
        hcr_pkg::OFS_PORT_CFG + 12'(4 * gp);
      logic fast_ok;
      logic [5:0] limit;

      // Each port set on its own, spare bits kept as written
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          port_cfg[gp] <= hcr_pkg::REG_RESET_VAL;
        end else if (sw_reset) begin
          port_cfg[gp] <= hcr_pkg::REG_RESET_VAL;
        end else if (wr && ofs == PORT_OFS) begin
          port_cfg[gp] <= wb_dat_i[15:0];
        end
      end

      // Fast engine only exists on the low ports
      assign fast_ok = gp < hcr_pkg::NUM_FAST_PORTS;
      assign limit = (fast_ok && port_cfg[gp].fast)
        ? 6'(hcr_pkg::FAST_RATE_MBPS)
        : 6'(hcr_pkg::SLOW_RATE_MBPS);
      assign rate_err[gp] = port_cfg[gp].en && !port_cfg[gp].chan
        && port_cfg[gp].rate > limit;
      assign fast_err[gp] = port_cfg[gp].fast && !fast_ok;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Aggregate capacity checks
  logic [9:0] thru_sum;
  logic [6:0] line_sum;
  always_comb begin
    thru_sum = '0;
    line_sum = '0;
    for (int p = 0; p < NP; p++) begin
      if (port_cfg[p].en && !port_cfg[p].chan) begin
        thru_sum = thru_sum + 10'(port_cfg[p].rate);
      end
      if (port_cfg[p].en && port_cfg[p].chan) begin
        unique case (port_cfg[p].lines)
          2'd0: line_sum = line_sum + 7'd1;
          2'd1: line_sum = line_sum + 7'd2;
          default: line_sum = line_sum + 7'd4;
        endcase
      end
    end
  end

  // Status word, registered
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status <= hcr_pkg::REG_RESET_VAL;
    end else begin
      status <= '0;
      status[hcr_pkg::ST_READY_BIT] <= ports_ready;
      status[hcr_pkg::ST_RATE_BIT] <= |rate_err;
      status[hcr_pkg::ST_THRU_BIT] <=
        thru_sum > 10'(hcr_pkg::MAX_THRU_MBPS);
      status[hcr_pkg::ST_LINE_BIT] <=
        line_sum > 7'(hcr_pkg::MAX_LINES);
      status[hcr_pkg::ST_FAST_BIT] <= |fast_err;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Settle timer, restarted by a software reset
  logic timer_ready;
  hcr_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(sw_reset),
    .ready(timer_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // Indirect stores: never reset
  logic [15:0] cp_mem [NCP];
  logic [15:0] rx_fb_mem [NFB];
  logic [15:0] tx_fb_mem [NFB];
  logic [15:0] rx_start_mem [NCH];
  logic [15:0] rx_hwm_mem [NCH];
  logic [15:0] tx_start_mem [NCH];
  logic [15:0] tx_lwm_mem [NCH];
  logic [12:0] cp_idx;
  logic cp_ok;
  logic [9:0] fb_idx;
  logic [7:0] ch_idx;
  logic ch_ok;

  // Three words per timeslot per port
  assign cp_idx = 13'((cp_addr.port * hcr_pkg::NUM_TIMESLOTS
    + cp_addr.slot) * hcr_pkg::CP_REGS_PER_TS + cp_addr.sel);
  assign cp_ok = cp_addr.sel < 2'(hcr_pkg::CP_REGS_PER_TS);
  assign fb_idx = fb_addr[9:0];
  // Channel 1 maps to entry 0; channel 0 does not exist
  assign ch_ok = ch_addr[8:0] != 9'd0
    && ch_addr[8:0] <= 9'(NCH);
  assign ch_idx = 8'(ch_addr[8:0] - 9'd1);

  // Channelized port words
  always_ff @(posedge ref_clk) begin
    if (wr && cp_ok && ofs == hcr_pkg::OFS_CP_DATA) begin
      cp_mem[cp_idx] <= wb_dat_i[15:0];
    end
  end

  // FIFO block links
  always_ff @(posedge ref_clk) begin
    if (wr && ofs == hcr_pkg::OFS_RX_FB_DATA) begin
      rx_fb_mem[fb_idx] <= wb_dat_i[15:0];
    end
    if (wr && ofs == hcr_pkg::OFS_TX_FB_DATA) begin
      tx_fb_mem[fb_idx] <= wb_dat_i[15:0];
    end
  end

  // Per-channel pointers and watermarks
  always_ff @(posedge ref_clk) begin
    if (wr && ch_ok) begin
      if (ofs == hcr_pkg::OFS_RX_START) begin
        rx_start_mem[ch_idx] <= wb_dat_i[15:0];
      end
      if (ofs == hcr_pkg::OFS_RX_HWM) begin
        rx_hwm_mem[ch_idx] <= wb_dat_i[15:0];
      end
      if (ofs == hcr_pkg::OFS_TX_START) begin
        tx_start_mem[ch_idx] <= wb_dat_i[15:0];
      end
      if (ofs == hcr_pkg::OFS_TX_LWM) begin
        tx_lwm_mem[ch_idx] <= wb_dat_i[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read multiplexer
  logic [15:0] rd_word;
  logic [15:0] ch_word;
  always_comb begin
    ch_word = '0;
    unique case (ofs)
      hcr_pkg::OFS_RX_START: ch_word = rx_start_mem[ch_idx];
      hcr_pkg::OFS_RX_HWM: ch_word = rx_hwm_mem[ch_idx];
      hcr_pkg::OFS_TX_START: ch_word = tx_start_mem[ch_idx];
      hcr_pkg::OFS_TX_LWM: ch_word = tx_lwm_mem[ch_idx];
      default: ch_word = '0;
    endcase
  end

  always_comb begin
    rd_word = '0;
    if (ofs >= hcr_pkg::OFS_PORT_CFG
        && ofs < hcr_pkg::OFS_PORT_CFG + 12'(4 * NP)) begin
      rd_word = port_cfg[ofs[5:2]];
    end else begin
      unique case (ofs)
        hcr_pkg::OFS_RESET_ID:
          rd_word = {DEVICE_ID, 4'h0}; // reset bit reads 0
        hcr_pkg::OFS_MASTER_CFG: rd_word = master_config_reg;
        hcr_pkg::OFS_BRIDGE_MODE: rd_word = bridge_mode_control_reg;
        hcr_pkg::OFS_STATUS: rd_word = status;
        hcr_pkg::OFS_CP_ADDR: rd_word = cp_addr;
        hcr_pkg::OFS_CP_DATA:
          rd_word = cp_ok ? cp_mem[cp_idx] : '0;
        hcr_pkg::OFS_FB_ADDR: rd_word = fb_addr;
        hcr_pkg::OFS_RX_FB_DATA: rd_word = rx_fb_mem[fb_idx];
        hcr_pkg::OFS_TX_FB_DATA: rd_word = tx_fb_mem[fb_idx];
        hcr_pkg::OFS_CH_ADDR: rd_word = ch_addr;
        hcr_pkg::OFS_RX_START, hcr_pkg::OFS_RX_HWM,
        hcr_pkg::OFS_TX_START, hcr_pkg::OFS_TX_LWM:
          rd_word = ch_ok ? ch_word : '0;
        default: rd_word = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus answer: one cycle after a request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i && lane) begin
        wb_dat_o <= {16'h0000, rd_word};
      end else if (req) begin
        wb_dat_o <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs to the datapath blocks
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_dma_global_enable <= 1'b0;
      tx_dma_global_enable <= 1'b0;
      bridge_mode <= '0;
      ports_ready <= 1'b0;
      port_run <= '0;
      port_channelized <= '0;
    end else begin
      rx_dma_global_enable <= master_config_reg[hcr_pkg::RX_DMA_BIT];
      tx_dma_global_enable <= master_config_reg[hcr_pkg::TX_DMA_BIT];
      bridge_mode <= bridge_mode_control_reg;
      ports_ready <= timer_ready && !sw_reset;
      for (int p = 0; p < NP; p++) begin
        // No packet data before the port has settled
        port_run[p] <= port_cfg[p].en && timer_ready
          && !sw_reset;
        port_channelized[p] <= port_cfg[p].chan;
      end
    end
  end

endmodule

// [tb/hcr_bank_checker.sv]
// Checker for bus answers, reset and settle rules of the config bank.
// Assumes it is bound to hcr_config_bank and sees only its ports.
`timescale 1ns/100ps
module hcr_bank_checker #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_dma_global_enable,
  input wire logic tx_dma_global_enable,
  input wire logic [15:0] bridge_mode,
  input wire logic ports_ready,
  input wire logic [15:0] port_run
);
  logic req;
  logic lane;
  logic wr_bridge;
  logic wr_mcfg;
  logic sw_rst;
  logic [15:0] since_rst;
  ////////////////////////////////////////
  // Request decodes
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane = wb_sel_i != 4'h0;
  assign wr_bridge = req && wb_we_i && wb_adr_i[11:2] == 10'h002;
  assign wr_mcfg = req && wb_we_i && lane && wb_adr_i[11:2] == 10'h001;
  assign sw_rst = req && wb_we_i && lane && wb_adr_i[11:2] == 10'h000 && wb_dat_i[0];
  // Cycles since last hardware or software reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      since_rst <= 16'h0000;
    end else if (sw_rst) begin
      since_rst <= 16'h0000;
    end else if (since_rst != 16'hFFFF) begin
      since_rst <= since_rst + 16'h0001;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_caused: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper half set");
  a_nolane_read: assert property (req && !wb_we_i && !lane |=> wb_dat_o == 32'h0000_0000)
    else $error("no lane read data");
  a_nolane_write: assert property (wr_bridge && !lane |=> ##1 bridge_mode == $past(bridge_mode, 2))
    else $error("no lane write took");
  a_bridge_write: assert property (wr_bridge && lane |=> ##1 bridge_mode == $past(wb_dat_i[15:0], 2))
    else $error("bridge write lost");
  a_dma_write: assert property (wr_mcfg |=> ##1
    {tx_dma_global_enable, rx_dma_global_enable} == $past(wb_dat_i[1:0], 2)) else $error("dma enables");
  a_sw_clear: assert property (sw_rst |=> ##1 !rx_dma_global_enable && !tx_dma_global_enable
    && bridge_mode == $past(bridge_mode, 2)) else $error("soft reset result");
  a_settle_restart: assert property (sw_rst |-> ##[1:4] !ports_ready) else $error("ready kept");
  a_settle_time: assert property ($rose(ports_ready) |-> since_rst >= SETTLE_CYCLES)
    else $error("ready too early");
  a_run_settled: assert property (|port_run |-> since_rst > SETTLE_CYCLES)
    else $error("port runs unsettled");
  c_sw_reset: cover property (sw_rst);
  c_nolane: cover property (req && !lane);
  c_ready: cover property ($rose(ports_ready));
endmodule
bind hcr_config_bank hcr_bank_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) hcr_bank_checker_i (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_dma_global_enable(rx_dma_global_enable),
  .tx_dma_global_enable(tx_dma_global_enable), .bridge_mode(bridge_mode),
  .ports_ready(ports_ready), .port_run(port_run));

// [tb/hcr_host_model.sv]
// Host on the register bus: classic Wishbone single cycles.
// Assumes the bench calls xfer and checks the ok flag.
`timescale 1ns/100ps
module hcr_host_model (
  input wire logic ref_clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [11:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  // Idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    wdat = 32'h0000_0000;
  end
  // One request held until ack; released lines show inverted values
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [15:0] d,
    output logic [31:0] q, output logic ok);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    ok = ack === 1'b1;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= ~w;
    adr <= ~a;
    sel <= ~s;
    wdat <= ~{16'h0000, d};
  endtask
endmodule

// [tb/config_register_reset_init_test.sv]
// Self-checking bench for the configuration bank.
// Assumes the host model drives the bus on a 50 MHz clock.
`timescale 1ns/100ps
module config_register_reset_init_test;
  localparam int unsigned SETTLE = 20;
  // Identity value is arbitrary
  localparam logic [11:0] DEV_ID = 12'h3C7;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc, stb, we, ack, rx_en, tx_en, rdy;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] bridge, run, chan;
  int num_errors = 0;
  int n_compared = 0;
  ////////////////////////////////////////
  // Clock and instances
  always #10 ref_clk = ~ref_clk;
  hcr_config_bank #(.SETTLE_CYCLES(SETTLE), .DEVICE_ID(DEV_ID)) hcr_config_bank_i (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_dma_global_enable(rx_en),
    .tx_dma_global_enable(tx_en), .bridge_mode(bridge), .ports_ready(rdy), .port_run(run),
    .port_channelized(chan));
  hcr_host_model hcr_host_model_i (.ref_clk(ref_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wdat(wdat));
  ////////////////////////////////////////
  // Verdict and compares
  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Bus access; a missing ack ends the run
  task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [15:0] d,
    output logic [31:0] q);
    logic ok;
    hcr_host_model_i.xfer(w, a, s, d, q, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error bus ack expected 1 seen none");
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, 4'hF, d, q);
    @(negedge ref_clk);
  endtask
  task automatic chk(input logic [11:0] a, input logic [15:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 4'hF, 16'h0000, q);
    cmp16(what, exp, q[15:0]);
    cmp16("read upper half", 16'h0000, q[31:16]);
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic apply_reset();
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task automatic check_settle(input int lo, input int hi);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    cmp1("ready not early", 1'b1, n >= lo);
    cmp1("ready not late", 1'b1, n <= hi);
    if (n >= 200) print_verdict();
  endtask
  task automatic check_reset_values();
    logic [11:0] ofs [5] = '{12'h004, 12'h008, 12'h054, 12'h100, 12'h13C};
    logic [31:0] q;
    foreach (ofs[i]) chk(ofs[i], 16'h0000, "reset value");
    bus(1'b0, 12'h000, 4'h1, 16'h0000, q);
    cmp16("device id", {4'h0, DEV_ID}, {4'h0, q[15:4]});
  endtask
  task automatic check_rw_outputs();
    wr(12'h004, 16'h0003);
    cmp1("rx dma", 1'b1, rx_en);
    cmp1("tx dma", 1'b1, tx_en);
    wr(12'h008, 16'hA5C3);
    cmp16("bridge out", 16'hA5C3, bridge);
    chk(12'h008, 16'hA5C3, "bridge read");
    wr(12'h104, 16'h0003);
    cmp1("port chan", 1'b1, chan[1]);
    cmp1("port run", 1'b1, run[1]);
    wr(12'h00C, 16'h001E);
    chk(12'h00C, 16'h0001, "status read only");
  endtask
  task automatic check_byte_lanes();
    logic [31:0] q;
    bus(1'b1, 12'h008, 4'h0, 16'h1111, q);
    chk(12'h008, 16'hA5C3, "no lane write");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 12'h008, 4'h1 << i, 16'h0001 << i, q);
      chk(12'h008, 16'h0001 << i, "one lane write");
    end
    bus(1'b0, 12'h008, 4'h0, 16'h0000, q);
    cmp16("no lane read", 16'h0000, q[15:0]);
  endtask
  task automatic check_rate_limits();
    logic [11:0] ofs [7] = '{12'h10C, 12'h10C, 12'h100, 12'h100, 12'h104, 12'h108, 12'h10C};
    logic [15:0] cfg [7] = '{16'h002D, 16'h0029, 16'h04D5, 16'h04D1, 16'h04D1, 16'h04D1, 16'h0429};
    logic [15:0] st [7] = '{16'h0003, 16'h0001, 16'h0003, 16'h0001, 16'h0001, 16'h0005, 16'h0015};
    foreach (ofs[i]) begin
      wr(ofs[i], cfg[i]);
      chk(12'h00C, st[i], "limit status");
    end
    // Every port channelized with four lines: exactly at the line limit
    for (int p = 0; p < 16; p++) begin
      wr(12'h100 + 12'(4 * p), 16'h0303);
    end
    cmp16("all channelized", 16'hFFFF, chan);
    chk(12'h00C, 16'h0001, "line sum at limit");
  endtask
  // Indirect stores first, then functional registers, then soft reset
  task automatic check_soft_reset();
    wr(12'h054, 16'h0001);
    wr(12'h058, 16'h0123);
    wr(12'h054, 16'h0100);
    wr(12'h058, 16'h0256);
    wr(12'h054, 16'h0000);
    wr(12'h058, 16'h0777);
    chk(12'h058, 16'h0000, "channel zero");
    wr(12'h040, 16'h0001);
    wr(12'h044, 16'h0BEE);
    wr(12'h048, 16'h03FF);
    wr(12'h04C, 16'h1111);
    wr(12'h050, 16'h2222);
    wr(12'h008, 16'hA5C3);
    wr(12'h004, 16'h0003);
    wr(12'h000, 16'h0001);
    repeat (4) @(posedge ref_clk);
    cmp1("dma after soft reset", 1'b0, rx_en);
    cmp1("ready after soft reset", 1'b0, rdy);
    cmp16("run after soft reset", 16'h0000, run);
    cmp16("bridge kept", 16'hA5C3, bridge);
    chk(12'h054, 16'h0000, "chan addr cleared");
    chk(12'h040, 16'h0000, "slot addr cleared");
    chk(12'h108, 16'h0000, "port cfg cleared");
    check_settle(SETTLE - 14, SETTLE + 3);
    wr(12'h054, 16'h0001);
    chk(12'h058, 16'h0123, "rx start kept");
    wr(12'h054, 16'h0100);
    chk(12'h058, 16'h0256, "last channel kept");
    wr(12'h040, 16'h0001);
    chk(12'h044, 16'h0BEE, "slot word kept");
    chk(12'h048, 16'h0000, "block addr cleared");
    wr(12'h048, 16'h03FF);
    chk(12'h04C, 16'h1111, "rx link kept");
    chk(12'h050, 16'h2222, "tx link kept");
  endtask
  task automatic check_hard_reset();
    apply_reset();
    cmp16("bridge cleared", 16'h0000, bridge);
    check_settle(SETTLE, SETTLE + 3);
    wr(12'h054, 16'h0001);
    chk(12'h058, 16'h0123, "rx start kept");
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    apply_reset();
    check_settle(SETTLE, SETTLE + 3);
    check_reset_values();
    check_rw_outputs();
    check_byte_lanes();
    check_rate_limits();
    check_soft_reset();
    check_hard_reset();
    print_verdict();
  end
endmodule
